/* shared/rtc_mode_pkg.sv */
package rtc_mode_pkg;
  // ==========================================================
  // register map, byte addresses on the AXI4-Lite port
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_PRESET = 6'h04;
  localparam logic [5:0] OFF_OBJS = 6'h08;
  localparam logic [5:0] OFF_LOCAL = 6'h0c;
  localparam logic [5:0] OFF_BASE = 6'h10;
  localparam logic [5:0] OFF_OFFSET = 6'h14;
  localparam logic [5:0] OFF_REDUCE = 6'h18;
  localparam logic [5:0] OFF_FROST = 6'h1c;
  localparam logic [5:0] OFF_HEAT = 6'h20;
  localparam logic [5:0] OFF_EXTEND = 6'h24;
  localparam logic [5:0] OFF_STATUS = 6'h28;

  // ==========================================================
  // field positions
  localparam int CTRL_NEW_BIT = 0;
  localparam int CTRL_PBTN_BIT = 1;
  localparam int OBJ_PRES_BIT = 0;
  localparam int OBJ_WIN_BIT = 1;
  localparam int OBJ_COMF_BIT = 2;
  localparam int OBJ_NIGHT_BIT = 3;
  localparam int OBJ_FROST_BIT = 4;
  localparam int ST_PRES_BIT = 4;
  localparam int ST_WIN_BIT = 5;
  localparam int ST_EXT_BIT = 6;
  localparam int ST_SP_LSB = 16;

  // ==========================================================
  // reset values; temperatures in 0.1 degree steps, signed
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [15:0] BASE_RST = 16'h00d2;
  localparam logic [15:0] OFFSET_RST = 16'h0000;
  localparam logic [15:0] REDUCE_RST = 16'h0014;
  localparam logic [15:0] FROST_RST = 16'h0046;
  localparam logic [15:0] HEAT_RST = 16'h015e;
  localparam logic [15:0] EXTEND_RST = 16'h0e10;

  // ==========================================================
  // operating modes and their 2-bit request codes
  typedef enum logic [3:0] {
    M_COMFORT = 4'b0001,
    M_STANDBY = 4'b0010,
    M_NIGHT = 4'b0100,
    M_FROST = 4'b1000
  } mode_t;
  localparam logic [1:0] CODE_COMFORT = 2'h0;
  localparam logic [1:0] CODE_STANDBY = 2'h1;
  localparam logic [1:0] CODE_NIGHT = 2'h2;
  localparam logic [1:0] CODE_FROST = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // timing: comfort extension counts in one-second ticks
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYC_1S = TICK_PERIOD_NS / CLK_PERIOD_NS;

  function automatic mode_t code_to_mode(input logic [1:0] c);
    case (c)
      CODE_COMFORT: code_to_mode = M_COMFORT;
      CODE_STANDBY: code_to_mode = M_STANDBY;
      CODE_NIGHT: code_to_mode = M_NIGHT;
      default: code_to_mode = M_FROST;
    endcase
  endfunction : code_to_mode

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    merge_bytes = r;
  endfunction : merge_bytes
endpackage : rtc_mode_pkg

/* sim/bus_sender.sv */
`timescale 1ns/1ps
// ==========================================================
// register bus master standing in for the telegram sources
module bus_sender
  import rtc_mode_pkg::*;
(
  input wire logic MCLK,
  output logic AWVALID,
  input wire logic AWREADY,
  output logic [ADDR_W-1:0] AWADDR,
  output logic WVALID,
  input wire logic WREADY,
  output logic [31:0] WDATA,
  input wire logic BVALID,
  output logic BREADY,
  output logic ARVALID,
  input wire logic ARREADY,
  output logic [ADDR_W-1:0] ARADDR,
  input wire logic RVALID,
  output logic RREADY
);
  // idle bus at time zero
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, WDATA} = '0;
  end
  // one telegram; dly stalls the answer to test slow acceptance
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
      input int dly);
    @(posedge MCLK);
    {AWVALID, WVALID} <= 2'h3;
    AWADDR <= a;
    WDATA <= d;
    do begin
      @(posedge MCLK);
      if (AWREADY) begin
        AWVALID <= 1'b0;
        AWADDR <= ~a;
      end
      if (WREADY) begin
        WVALID <= 1'b0;
        WDATA <= ~d;
      end
    end while (AWVALID || WVALID);
    repeat (dly) @(posedge MCLK);
    BREADY <= 1'b1;
    do @(posedge MCLK); while (!BVALID);
    BREADY <= 1'b0;
  endtask : wr
  // one read; data are taken by the bench's watcher
  task automatic rd(input logic [ADDR_W-1:0] a, input int dly);
    @(posedge MCLK);
    ARVALID <= 1'b1;
    ARADDR <= a;
    do @(posedge MCLK); while (!ARREADY);
    ARVALID <= 1'b0;
    ARADDR <= ~a;
    repeat (dly) @(posedge MCLK);
    RREADY <= 1'b1;
    do @(posedge MCLK); while (!RVALID);
    RREADY <= 1'b0;
  endtask : rd
endmodule : bus_sender

/* sim/room_mode_monitor.sv */
`timescale 1ns/1ps
module room_mode_monitor
  import rtc_mode_pkg::*;
#(
  parameter int unsigned EXT_TICK_CYCLES = 10
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic [3:0] MODE,
  input wire logic PRESENCE
);
  // ==========================================================
  // cycles since the last write answer or presence change
  logic [3:0] quiet;
  logic pres_d;
  always_ff @(posedge MCLK) begin
    if (RST || BVALID || PRESENCE != pres_d) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  // previous presence, reset not needed: both are 0 out of reset
  always_ff @(posedge MCLK) begin
    pres_d <= PRESENCE;
  end

  // ==========================================================
  // properties
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  mode_onehot_a: assert property (!$past(RST) && !$past(RST, 2) &&
    !$past(RST, 3) |-> $onehot(MODE)) else $error("mode not one-hot");
  mode_quiet_a: assert property ($changed(MODE) |-> quiet < 4'h6)
    else $error("mode moved without an event");
  write_resp_a: assert property (AWVALID && AWREADY && WVALID && WREADY
    |-> ##[1:2] BVALID) else $error("write not answered");
  read_resp_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read not answered");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write answer dropped");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read answer dropped");
  w_busy_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while answering");
  bresp_code_a: assert property (BVALID |-> BRESP == RESP_OKAY ||
    BRESP == RESP_SLVERR) else $error("bad write response code");
  cover property (BVALID && BREADY && BRESP == RESP_SLVERR);
  cover property ($fell(PRESENCE));
  cover property (MODE == M_STANDBY && $past(MODE) == M_FROST);
endmodule : room_mode_monitor

bind room_mode_select room_mode_monitor #(
  .EXT_TICK_CYCLES(EXT_TICK_CYCLES)
) u_mon (.MCLK, .RST, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID,
  .BREADY, .BRESP, .ARVALID, .ARREADY, .RVALID, .RREADY, .RDATA, .MODE,
  .PRESENCE);

/* sim/test_room_mode_select.sv */
`timescale 1ns/1ps
module test_room_mode_select
  import rtc_mode_pkg::*;
;
  logic MCLK = 1'b0, RST = 1'b1, AWVALID, AWREADY, WVALID, WREADY, BVALID;
  logic BREADY, ARVALID, ARREADY, RVALID, RREADY, PRESENCE;
  logic [ADDR_W-1:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [1:0] BRESP, RRESP;
  logic [3:0] MODE;
  logic [15:0] SETPOINT;
  logic signed [15:0] base, off, red, frs, hot;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [21:0] pq[$];
  logic [21:0] pe;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  integer seed;
  mode_t mt[4] = '{M_COMFORT, M_STANDBY, M_NIGHT, M_FROST};
  logic [4:0] ov[6] = '{5'h04, 5'h0c, 5'h08, 5'h10, 5'h02, 5'h00};
  mode_t om[6] = '{M_COMFORT, M_COMFORT, M_NIGHT, M_FROST, M_FROST, M_STANDBY};

  // ==========================================================
  // clock, design and partner
  always #2.5 MCLK = ~MCLK;
  room_mode_select #(.EXT_TICK_CYCLES(10)) dut (.MCLK, .RST, .AWVALID,
    .AWREADY, .AWADDR, .AWPROT(3'h0), .WVALID, .WREADY, .WDATA,
    .WSTRB(4'hf), .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR,
    .ARPROT(3'h0), .RVALID, .RREADY, .RDATA, .RRESP, .MODE, .PRESENCE,
    .SETPOINT);
  bus_sender src (.MCLK, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY,
    .WDATA, .BVALID, .BREADY, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY);

  // ==========================================================
  // expectations and checking
  function automatic logic [15:0] sp_of(input mode_t m);
    logic signed [15:0] v;
    v = base + off;
    if (m != M_COMFORT) v = v - red;
    if (m == M_FROST) v = frs;
    if (v < frs) v = frs;
    if (v > hot) v = hot;
    sp_of = v;
  endfunction : sp_of
  task automatic cmp(input logic [33:0] e, input logic [33:0] g,
      input string what);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  // write, then let the walk settle mode and setpoint
  task automatic put(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bq.push_back((a[1:0] == 2'h0 && a <= OFF_STATUS) ? RESP_OKAY : RESP_SLVERR);
    src.wr(a, d, $random(seed) & 3);
    repeat (6) @(posedge MCLK);
  endtask : put
  task automatic get(input logic [ADDR_W-1:0] a, input logic [33:0] e);
    rq.push_back(e);
    // status reads also note what the mode, presence and setpoint pins show
    pq.push_back({a == OFF_STATUS, e[31:16], e[4], e[3:0]});
    src.rd(a, $random(seed) & 3);
  endtask : get
  task automatic chk(input mode_t m, input logic p, w, x);
    get(OFF_STATUS, {RESP_OKAY, sp_of(m), 9'h0, x, w, p, 4'(m)});
  endtask : chk
  // watcher: each answer takes the oldest note
  always @(posedge MCLK) begin
    if (RVALID && RREADY) begin
      cmp(rq.size() ? rq.pop_front() : 34'h0, {RRESP, RDATA}, "read");
      pe = pq.size() ? pq.pop_front() : 22'h0;
      if (pe[21]) begin
        cmp({13'h0, pe[20:0]}, {13'h0, SETPOINT, PRESENCE, MODE}, "pins");
      end
    end
    if (BVALID && BREADY) begin
      cmp({32'h0, bq.size() ? bq.pop_front() : 2'h1}, {32'h0, BRESP}, "bresp");
    end
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // scenarios
  initial begin
    seed = 32'hff462363;
    {base, off, red, frs, hot} = {BASE_RST, 16'h0, REDUCE_RST, FROST_RST, HEAT_RST};
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    get(OFF_CTRL, {RESP_OKAY, 30'h0, CTRL_RST});
    get(OFF_EXTEND, {RESP_OKAY, 16'h0, EXTEND_RST});
    chk(M_COMFORT, 1'b0, 1'b0, 1'b0);
    $display("reset values done");
    off = 16'($random(seed) % 21);
    put(OFF_OFFSET, {16'h0, off});
    put(OFF_OFFSET, {16'h0, off});
    for (int c = 0; c < 4; c++) begin
      put(OFF_PRESET, c);
      chk(mt[c], 1'b0, 1'b0, 1'b0);
    end
    $display("preset modes done");
    put(OFF_PRESET, 32'h1);
    put(OFF_OBJS, 32'h3);
    chk(M_FROST, 1'b1, 1'b1, 1'b0);
    put(OFF_OBJS, 32'h1);
    put(OFF_PRESET, 32'h2);
    chk(M_COMFORT, 1'b1, 1'b0, 1'b0);
    put(OFF_OBJS, 32'h0);
    chk(M_NIGHT, 1'b0, 1'b0, 1'b0);
    put(OFF_LOCAL, 32'h0);
    chk(M_COMFORT, 1'b0, 1'b0, 1'b0);
    put(OFF_PRESET, 32'h1);
    chk(M_STANDBY, 1'b0, 1'b0, 1'b0);
    put(OFF_OBJS, 32'h2);
    put(OFF_LOCAL, 32'h0);
    chk(M_FROST, 1'b0, 1'b1, 1'b0);
    put(OFF_OBJS, 32'h0);
    $display("sources done");
    base = 16'sh0190;
    put(OFF_BASE, {16'h0, base});
    chk(M_COMFORT, 1'b0, 1'b0, 1'b0);
    base = 16'sh0032;
    put(OFF_BASE, {16'h0, base});
    chk(M_COMFORT, 1'b0, 1'b0, 1'b0);
    $display("limits done");
    put(OFF_CTRL, 32'h0);
    for (int i = 0; i < 6; i++) begin
      put(OFF_OBJS, {27'h0, ov[i]});
      chk(om[i], 1'b0, ov[i][1], 1'b0);
    end
    put(OFF_OBJS, 32'h2);
    put(OFF_LOCAL, 32'h2);
    chk(M_FROST, 1'b0, 1'b1, 1'b0);
    put(OFF_OBJS, 32'h0);
    $display("old scheme done");
    put(OFF_CTRL, 32'h3);
    put(OFF_EXTEND, 32'h8);
    put(OFF_PRESET, 32'h2);
    put(OFF_OBJS, 32'h1);
    chk(M_COMFORT, 1'b1, 1'b0, 1'b1);
    put(OFF_PRESET, 32'h2);
    chk(M_COMFORT, 1'b1, 1'b0, 1'b1);
    repeat (100) @(posedge MCLK);
    chk(M_NIGHT, 1'b0, 1'b0, 1'b0);
    put(OFF_PRESET, 32'h1);
    put(OFF_OBJS, 32'h1);
    repeat (120) @(posedge MCLK);
    chk(M_COMFORT, 1'b1, 1'b0, 1'b0);
    put(OFF_PRESET, 32'h3);
    chk(M_FROST, 1'b0, 1'b0, 1'b0);
    $display("presence done");
    put(6'h2c, 32'h1);
    put(6'h05, 32'h1);
    get(6'h2c, {RESP_SLVERR, 32'h0});
    put(OFF_STATUS, 32'h0);
    chk(M_FROST, 1'b0, 1'b0, 1'b0);
    $display("refusals done");
    repeat (4) @(posedge MCLK);
    end_sim();
  end
endmodule : test_room_mode_select

/* src/room_mode_select.sv */
// Function
// - preset object, button and scene share priority; latest request wins
// - window-contact frost request overrides every other mode source
// - with presence button, new preset during presence is taken, presence cleared
// - preset equal to the pre-presence mode is ignored, presence stays
// - presence from night or frost ends after comfort extension time
// - presence from standby gives comfort with no time limit
// - a configuration bit picks the new or old object scheme
// - new scheme: window state 1 forces frost/heat protection
// - new scheme: window 0 and presence 1 give comfort
// - new scheme: presence and window 0 follow the preset value
// - old scheme: frost object, then comfort object, then night/standby object
// - old scheme: closing window clears time-switch frost, shared object
// - heating comfort: base setpoint plus offset
// - heating standby and night: base plus offset minus standby reduction
// - heating frost mode: configured frost setpoint replaces everything
// - offset always relative to base setpoint, never accumulated
// - setpoint clamped between frost and heat protection values
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module room_mode_select
  import rtc_mode_pkg::*;
#(
  parameter int unsigned EXT_TICK_CYCLES = TICK_CYC_1S
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic [3:0] MODE,
  output logic PRESENCE,
  output logic [15:0] SETPOINT
);
  // ==========================================================
  // bus slave: address and data latched independently
  logic aw_full, w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, rd_fire, wr_ok, rd_ok;
  logic [31:0] rd_data;

  assign wr_fire = aw_full & w_full & ~BVALID;
  assign rd_fire = ARVALID & ARREADY;

  // address-map membership; unmapped words answer with an error
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFF_STATUS);
  endfunction : mapped

  assign wr_ok = mapped(aw_addr);
  assign rd_ok = mapped(ARADDR);

  // write channel handshakes; ready drops once a beat is held
  always_ff @(posedge MCLK) begin
    if (RST) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_full <= 1'b1;
        aw_addr <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_full <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
        WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // read channel: one outstanding read, data registered
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= RESP_OKAY;
    end else if (rd_fire) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_ok ? rd_data : 32'h00000000;
      RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // ==========================================================
  // configuration registers
  logic [1:0] ctrl;
  logic [15:0] base, offs, reduce, frost_sp, heat_sp, ext_time;
  logic ctrl_wr, preset_wr, obj_wr, local_wr;
  logic scheme_new, pbtn_opt;
  mode_t wr_mode;

  assign ctrl_wr = wr_fire & (aw_addr == OFF_CTRL);
  assign preset_wr = wr_fire & (aw_addr == OFF_PRESET) & w_strb[0];
  assign obj_wr = wr_fire & (aw_addr == OFF_OBJS) & w_strb[0];
  assign local_wr = wr_fire & (aw_addr == OFF_LOCAL) & w_strb[0];
  assign wr_mode = code_to_mode(w_data[1:0]);
  assign scheme_new = ctrl[CTRL_NEW_BIT];
  assign pbtn_opt = ctrl[CTRL_PBTN_BIT];

  // 16-bit value words, byte lanes honoured
  function automatic logic [15:0] upd(input logic [15:0] old);
    logic [31:0] m;
    m = merge_bytes({16'h0000, old}, w_data, w_strb);
    upd = m[15:0];
  endfunction : upd

  always_ff @(posedge MCLK) begin
    if (RST) begin
      ctrl <= CTRL_RST;
      base <= BASE_RST;
      offs <= OFFSET_RST;
      reduce <= REDUCE_RST;
      frost_sp <= FROST_RST;
      heat_sp <= HEAT_RST;
      ext_time <= EXTEND_RST;
    end else if (wr_fire) begin
      if (ctrl_wr && w_strb[0]) begin
        ctrl <= w_data[1:0];
      end
      if (aw_addr == OFF_BASE) base <= upd(base);
      if (aw_addr == OFF_OFFSET) offs <= upd(offs);
      if (aw_addr == OFF_REDUCE) reduce <= upd(reduce);
      if (aw_addr == OFF_FROST) frost_sp <= upd(frost_sp);
      if (aw_addr == OFF_HEAT) heat_sp <= upd(heat_sp);
      if (aw_addr == OFF_EXTEND) ext_time <= upd(ext_time);
    end
  end

  // ==========================================================
  // mode sources and presence handling
  mode_t sel_mode, pre_mode, mode, next_sel, next_pre, next_mode;
  mode_t new_mode, old_mode;
  logic presence, window, o_comf, o_night, o_frost, ext_run;
  logic next_pres, next_win, next_comf, next_night, next_frost;
  logic next_run, ext_start, ext_expire, tick, evt, evt_q;
  logic [31:0] tick_cnt;
  logic [15:0] ext_cnt;
  logic pres_in, win_in;

  assign pres_in = w_data[OBJ_PRES_BIT];
  assign win_in = w_data[OBJ_WIN_BIT];

  always_comb begin
    next_sel = sel_mode;
    next_pre = pre_mode;
    next_pres = presence;
    next_win = window;
    next_comf = o_comf;
    next_night = o_night;
    next_frost = o_frost;
    next_run = ext_run;
    if (preset_wr) begin
      if (pbtn_opt && presence) begin
        // cyclic repeats of the old mode must not end presence
        if (wr_mode != pre_mode) begin
          next_sel = wr_mode;
          next_pres = 1'b0;
          next_run = 1'b0;
        end
      end else begin
        next_sel = wr_mode;
      end
    end
    if (local_wr) begin
      // button and scene also steer the old-scheme objects
      next_sel = wr_mode;
      next_comf = (wr_mode == M_COMFORT);
      next_night = (wr_mode == M_NIGHT);
      // an open window keeps the shared frost object set: window wins
      next_frost = (wr_mode == M_FROST) | window;
    end
    if (obj_wr) begin
      if (pres_in && !presence) begin
        next_pre = sel_mode;
        // only night or frost start the extension timer
        next_run = (sel_mode == M_NIGHT) || (sel_mode == M_FROST);
      end else if (!pres_in) begin
        next_run = 1'b0;
      end
      next_pres = pres_in;
      next_win = win_in;
      next_comf = w_data[OBJ_COMF_BIT];
      next_night = w_data[OBJ_NIGHT_BIT];
      // window and time switch share the frost object
      next_frost = w_data[OBJ_FROST_BIT] | win_in;
    end
    if (ext_expire) begin
      next_pres = 1'b0;
      next_run = 1'b0;
    end
  end

  assign ext_start = next_run & ~ext_run;

  // new scheme: window first, presence second, preset last
  assign new_mode = window ? M_FROST :
                    presence ? M_COMFORT :
                    sel_mode;
  // old scheme: frost, comfort, then night/standby object
  assign old_mode = o_frost ? M_FROST :
                    o_comf ? M_COMFORT :
                    o_night ? M_NIGHT : M_STANDBY;
  assign next_mode = scheme_new ? new_mode : old_mode;
  assign evt = ctrl_wr | preset_wr | obj_wr | local_wr | ext_expire;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      sel_mode <= M_COMFORT;
      pre_mode <= M_COMFORT;
      presence <= 1'b0;
      window <= 1'b0;
      o_comf <= 1'b1;
      o_night <= 1'b0;
      o_frost <= 1'b0;
      ext_run <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      sel_mode <= next_sel;
      pre_mode <= next_pre;
      presence <= next_pres;
      window <= next_win;
      o_comf <= next_comf;
      o_night <= next_night;
      o_frost <= next_frost;
      ext_run <= next_run;
      evt_q <= evt;
    end
  end

  // resolved mode held between events
  always_ff @(posedge MCLK) begin
    if (RST) begin
      mode <= M_COMFORT;
    end else if (evt_q) begin
      mode <= next_mode;
    end
  end

  // ==========================================================
  // comfort extension: second divider then down-counter
  assign tick = ext_run && (tick_cnt == EXT_TICK_CYCLES - 1);
  assign ext_expire = tick && (ext_cnt <= 16'h0001);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      tick_cnt <= 32'h00000000;
      ext_cnt <= 16'h0000;
    end else if (ext_start || !ext_run) begin
      tick_cnt <= 32'h00000000;
      ext_cnt <= ext_time;
    end else if (tick) begin
      tick_cnt <= 32'h00000000;
      ext_cnt <= ext_cnt - 16'h0001;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end

  // ==========================================================
  // setpoint and outputs
  logic [15:0] sp;

  setpoint_calc u_sp (
    .clk(MCLK),
    .rst(RST),
    .mode(mode),
    .base(base),
    .offset(offs),
    .reduce(reduce),
    .frost(frost_sp),
    .heat(heat_sp),
    .setpoint(sp)
  );

  assign SETPOINT = sp;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      MODE <= 4'h0;
      PRESENCE <= 1'b0;
    end else begin
      MODE <= mode;
      PRESENCE <= presence;
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    case (ARADDR)
      OFF_CTRL: rd_data = {30'h0, ctrl};
      OFF_PRESET: rd_data = {28'h0, sel_mode};
      OFF_OBJS: rd_data = {27'h0, o_frost, o_night, o_comf,
                           window, presence};
      OFF_BASE: rd_data = {16'h0000, base};
      OFF_OFFSET: rd_data = {16'h0000, offs};
      OFF_REDUCE: rd_data = {16'h0000, reduce};
      OFF_FROST: rd_data = {16'h0000, frost_sp};
      OFF_HEAT: rd_data = {16'h0000, heat_sp};
      OFF_EXTEND: rd_data = {16'h0000, ext_time};
      OFF_STATUS: rd_data = {sp, 9'h000, ext_run, window, presence,
                             mode};
      default: rd_data = 32'h00000000;
    endcase
  end
endmodule : room_mode_select

/* src/setpoint_calc.sv */
`timescale 1ns/1ps
module setpoint_calc
  import rtc_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire mode_t mode,
  input wire logic [15:0] base,
  input wire logic [15:0] offset,
  input wire logic [15:0] reduce,
  input wire logic [15:0] frost,
  input wire logic [15:0] heat,
  output logic [15:0] setpoint
);
  // ==========================================================
  // heating setpoint per mode, widened so sums cannot wrap
  logic signed [17:0] base_x, offs_x, red_x, frost_x, heat_x;
  logic signed [17:0] raw;
  logic signed [17:0] next_sp;

  assign base_x = {{2{base[15]}}, base};
  assign offs_x = {{2{offset[15]}}, offset};
  assign red_x = {{2{reduce[15]}}, reduce};
  assign frost_x = {{2{frost[15]}}, frost};
  assign heat_x = {{2{heat[15]}}, heat};
  // offset always taken from the base, never stacked on the result
  assign raw = base_x + offs_x;

  // mode selection, then safety clamp
  always_comb begin
    case (mode)
      M_COMFORT: next_sp = raw;
      M_STANDBY: next_sp = raw - red_x;
      M_NIGHT: next_sp = raw - red_x;
      M_FROST: next_sp = frost_x;
      default: next_sp = frost_x;
    endcase
    if (next_sp < frost_x) begin
      next_sp = frost_x;
    end
    if (next_sp > heat_x) begin
      next_sp = heat_x;
    end
  end

  // registered so the output never glitches on a mode change
  always_ff @(posedge clk) begin
    if (rst) begin
      setpoint <= 16'h0000;
    end else begin
      setpoint <= next_sp[15:0];
    end
  end
endmodule : setpoint_calc
